// File: core/tmw_pkg.sv
/*
  Shared constants and carriers for the 8-bit waveform timer.
  Assumes an APB master on clk_sys and a port block that resolves the two pins.
*/
package tmw_pkg;

  // ********************
  // Register indices; byte address is four times the index
  // ********************
  localparam logic [7:0] IDX_CTRL_A = 8'hB0;
  localparam logic [7:0] IDX_CTRL_B = 8'hB1;
  localparam logic [7:0] IDX_COUNT = 8'hB2;
  localparam logic [7:0] IDX_CMP_A = 8'hB3;
  localparam logic [7:0] IDX_CMP_B = 8'hB4;
  localparam logic [7:0] IDX_FLAGS = 8'hB7;
  localparam logic [7:0] IDX_PORT = 8'hB8;

  // ********************
  // Field positions
  // ********************
  localparam int A_MODE_A_HI = 7;
  localparam int A_MODE_A_LO = 6;
  localparam int A_MODE_B_HI = 5;
  localparam int A_MODE_B_LO = 4;
  localparam int A_WGM_HI = 1;
  localparam int B_FORCE_A = 7;
  localparam int B_FORCE_B = 6;
  localparam int B_WGM_TOP = 3;
  localparam int B_CS_HI = 2;
  localparam int F_OVF = 0;
  localparam int F_CMP_A = 1;
  localparam int F_CMP_B = 2;
  localparam int P_DIR_A = 0;
  localparam int P_DIR_B = 1;
  localparam int P_DAT_A = 2;
  localparam int P_DAT_B = 3;

  // ********************
  // Reset values and writable masks
  // ********************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0F;
  localparam logic [7:0] PORT_MASK = 8'h0F;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;

  // ********************
  // Prescaler: tick when the low bits of a free counter are all ones
  // ********************
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] DIV1_MASK = 10'h000;
  localparam logic [PRE_W-1:0] DIV8_MASK = 10'h007;
  localparam logic [PRE_W-1:0] DIV32_MASK = 10'h01F;
  localparam logic [PRE_W-1:0] DIV64_MASK = 10'h03F;
  localparam logic [PRE_W-1:0] DIV128_MASK = 10'h07F;
  localparam logic [PRE_W-1:0] DIV256_MASK = 10'h0FF;
  localparam logic [PRE_W-1:0] DIV1024_MASK = 10'h3FF;

  typedef enum logic [2:0] {
    WG_NORMAL = 3'b000,
    WG_PC_FF = 3'b001,
    WG_CTC = 3'b010,
    WG_FAST_FF = 3'b011,
    WG_RSV4 = 3'b100,
    WG_PC_OCR = 3'b101,
    WG_RSV6 = 3'b110,
    WG_FAST_OCR = 3'b111
  } tmw_wgm_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmw_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmw_apb_rsp_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
    logic [1:0] override;
  } tmw_pins_t;

endpackage

// File: core/tmw_timer.sv
/*
  8-bit timer with two compare channels, waveform modes and an APB register file.
  Assumes one clock, an APB master that holds its request until pready, and
  a port block that drives each pin from out while oe is high.
*/
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps

// Functional notes
// - Nonzero channel B mode takes the pin; driver enabled only with direction set.
// - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM channel B: 10 clear match set TOP, 11 inverse, 01 reserved.
// - Compare equal TOP with high mode bit: match ignored, TOP action kept.
// - Phase correct channel B: 10 clear up set down, 11 inverse, 01 reserved.
// - Reserved bits of both control registers read zero.
// - Mode is two control A bits plus one control B bit; 4 and 6 reserved.
// - TOP is 0xFF in modes 0,1,3 and compare A in modes 2,5,7.
// - Compare update immediate or at TOP; overflow at MAX, BOTTOM or TOP.
// - In non-PWM modes the force bit applies an immediate match action per current output mode.
// - Force sets no flag, clears no counter, and reads back zero.
// - Clock select 001 undivided, 010..111 divide by 8,32,64,128,256,1024.
// - Clock select 000 stops the counter.
// - Counter register is directly readable and writable.
// - A counter write blocks compare match on the next timer tick.
// - Compare A is compared continuously; match sets flag or drives output A.
// - Compare B is compared continuously; match sets flag or drives output B.
// - PWM channel A mode 01 toggles on match when top mode bit set.
module tmw_timer (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire tmw_pkg::tmw_apb_req_t apbReq,
  output tmw_pkg::tmw_apb_rsp_t apbRsp,
  output tmw_pkg::tmw_pins_t pins,
  output logic [2:0] flags
);
  import tmw_pkg::*;

  // ********************
  // Registers
  // ********************
  logic [7:0] ctrlA_q;
  logic [7:0] ctrlB_q;
  logic [7:0] count_q;
  logic [7:0] cmpBuf_q [2];
  logic [7:0] cmpAct_q [2];
  logic [7:0] port_q;
  logic [2:0] flag_q;
  logic countDown_q;
  logic blockMatch_q;
  logic [PRE_W-1:0] pre_q;
  logic [1:0] wave_q;
  tmw_pins_t pins_q;
  tmw_apb_rsp_t rsp_q;

  // ********************
  // Bus decode
  // ********************
  logic access;
  logic doWrite;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic mapped;
  assign access = apbReq.psel & apbReq.penable;
  assign doWrite = access & apbReq.pwrite & rsp_q.pready & mapped;
  assign idx = apbReq.paddr[9:2];
  assign wbyte = apbReq.pwdata[7:0];
  assign mapped = (apbReq.paddr[11:10] == 2'b00) && (apbReq.paddr[1:0] == 2'b00) &&
                  (idx == IDX_CTRL_A || idx == IDX_CTRL_B || idx == IDX_COUNT ||
                   idx == IDX_CMP_A || idx == IDX_CMP_B || idx == IDX_FLAGS ||
                   idx == IDX_PORT);

  // ********************
  // Mode decode
  // ********************
  tmw_wgm_t wgm;
  logic isPc;
  logic isFast;
  logic nonPwm;
  logic [7:0] topVal;
  logic [1:0] chMode [2];
  assign wgm = tmw_wgm_t'({ctrlB_q[B_WGM_TOP], ctrlA_q[A_WGM_HI:0]});
  assign isPc = (wgm == WG_PC_FF) || (wgm == WG_PC_OCR);
  assign isFast = (wgm == WG_FAST_FF) || (wgm == WG_FAST_OCR);
  assign nonPwm = (wgm == WG_NORMAL) || (wgm == WG_CTC);
  assign topVal = (wgm == WG_CTC || wgm == WG_PC_OCR || wgm == WG_FAST_OCR) ?
                  cmpAct_q[0] : MAX_VAL;
  assign chMode[0] = ctrlA_q[A_MODE_A_HI:A_MODE_A_LO];
  assign chMode[1] = ctrlA_q[A_MODE_B_HI:A_MODE_B_LO];

  // ********************
  // Prescaler
  // ********************
  logic [PRE_W-1:0] preMask;
  logic tick;
  always_comb begin
    unique case (ctrlB_q[B_CS_HI:0])
      3'b001: preMask = DIV1_MASK;
      3'b010: preMask = DIV8_MASK;
      3'b011: preMask = DIV32_MASK;
      3'b100: preMask = DIV64_MASK;
      3'b101: preMask = DIV128_MASK;
      3'b110: preMask = DIV256_MASK;
      3'b111: preMask = DIV1024_MASK;
      default: preMask = DIV1_MASK;
    endcase
  end
  assign tick = (ctrlB_q[B_CS_HI:0] != 3'b000) && ((pre_q & preMask) == preMask);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ********************
  // Counter
  // ********************
  logic atTop;
  logic atBottom;
  logic countWr;
  assign atTop = (count_q == topVal);
  assign atBottom = (count_q == BOTTOM_VAL);
  assign countWr = doWrite && idx == IDX_COUNT;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= RST_BYTE;
      countDown_q <= 1'b0;
    end else if (countWr) begin
      count_q <= wbyte;
    end else if (tick) begin
      if (isPc) begin
        if (!countDown_q && atTop) begin
          countDown_q <= 1'b1;
          count_q <= count_q - 1'b1;
        end else if (countDown_q && atBottom) begin
          countDown_q <= 1'b0;
          count_q <= count_q + 1'b1;
        end else begin
          count_q <= countDown_q ? count_q - 1'b1 : count_q + 1'b1;
        end
      end else if ((wgm == WG_CTC || isFast) && atTop) begin
        count_q <= BOTTOM_VAL;
        countDown_q <= 1'b0;
      end else begin
        count_q <= count_q + 1'b1;
        countDown_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blockMatch_q <= 1'b0;
    end else if (countWr) begin
      blockMatch_q <= 1'b1;
    end else if (tick) begin
      blockMatch_q <= 1'b0;
    end
  end

  // ********************
  // Compare channels
  // ********************
  logic [1:0] match;
  logic [1:0] forceHit;
  logic tickTop;
  logic ovfEvent;
  assign tickTop = tick && atTop;
  assign forceHit[0] = doWrite && idx == IDX_CTRL_B && wbyte[B_FORCE_A] && nonPwm;
  assign forceHit[1] = doWrite && idx == IDX_CTRL_B && wbyte[B_FORCE_B] && nonPwm;
  assign ovfEvent = tick && (isPc ? (countDown_q && atBottom) :
                    (wgm == WG_FAST_OCR) ? atTop : (count_q == MAX_VAL));

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic cmpWr;
    logic eqTop;
    logic [7:0] cmpIdx;
    assign cmpIdx = (c == 0) ? IDX_CMP_A : IDX_CMP_B;
    assign cmpWr = doWrite && idx == cmpIdx;
    assign match[c] = tick && !blockMatch_q && (count_q == cmpAct_q[c]);
    assign eqTop = (cmpAct_q[c] == topVal) && chMode[c][1];

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        cmpBuf_q[c] <= RST_BYTE;
        cmpAct_q[c] <= RST_BYTE;
      end else begin
        if (cmpWr) begin
          cmpBuf_q[c] <= wbyte;
        end
        if (cmpWr && !(isPc || isFast)) begin
          cmpAct_q[c] <= wbyte;
        end else if (tickTop && (isPc || isFast)) begin
          cmpAct_q[c] <= cmpBuf_q[c];
        end
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        wave_q[c] <= 1'b0;
      end else if (forceHit[c] || (match[c] && nonPwm)) begin
        unique case (chMode[c])
          2'b01: wave_q[c] <= ~wave_q[c];
          2'b10: wave_q[c] <= 1'b0;
          2'b11: wave_q[c] <= 1'b1;
          default: wave_q[c] <= wave_q[c];
        endcase
      end else if (isFast) begin
        if (chMode[c][1] && tickTop) begin
          wave_q[c] <= ~chMode[c][0];
        end else if (chMode[c][1] && match[c] && !eqTop) begin
          wave_q[c] <= chMode[c][0];
        end else if (c == 0 && chMode[c] == 2'b01 && wgm[2] && match[c]) begin
          wave_q[c] <= ~wave_q[c];
        end
      end else if (isPc) begin
        if (chMode[c][1] && eqTop && tickTop) begin
          wave_q[c] <= ~chMode[c][0];
        end else if (chMode[c][1] && match[c] && !eqTop) begin
          wave_q[c] <= countDown_q ? ~chMode[c][0] : chMode[c][0];
        end else if (c == 0 && chMode[c] == 2'b01 && wgm[2] && match[c]) begin
          wave_q[c] <= ~wave_q[c];
        end
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        pins_q.out[c] <= 1'b0;
        pins_q.oe[c] <= 1'b0;
        pins_q.override[c] <= 1'b0;
      end else begin
        pins_q.override[c] <= chMode[c] != 2'b00;
        pins_q.out[c] <= (chMode[c] != 2'b00) ? wave_q[c] : port_q[P_DAT_A + c];
        pins_q.oe[c] <= port_q[P_DIR_A + c];
      end
    end
  end

  // ********************
  // Flags: set wins over a write-one clear
  // ********************
  logic [2:0] flagSet;
  logic [2:0] flagClr;
  assign flagSet = {match[1], match[0] && nonPwm || match[0], ovfEvent};
  assign flagClr = (doWrite && idx == IDX_FLAGS) ? wbyte[2:0] : 3'b000;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 3'b000;
    end else begin
      flag_q <= flagSet | (flag_q & ~flagClr);
    end
  end

  // ********************
  // Control and port registers
  // ********************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrlA_q <= RST_BYTE;
      ctrlB_q <= RST_BYTE;
      port_q <= RST_BYTE;
    end else if (doWrite) begin
      if (idx == IDX_CTRL_A) begin
        ctrlA_q <= wbyte & CTRL_A_MASK;
      end
      if (idx == IDX_CTRL_B) begin
        ctrlB_q <= wbyte & CTRL_B_MASK;
      end
      if (idx == IDX_PORT) begin
        port_q <= wbyte & PORT_MASK;
      end
    end
  end

  // ********************
  // APB response: one wait state, registered
  // ********************
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (idx == IDX_CTRL_A) begin
      rbyte = ctrlA_q;
    end else if (idx == IDX_CTRL_B) begin
      rbyte = ctrlB_q;
    end else if (idx == IDX_COUNT) begin
      rbyte = count_q;
    end else if (idx == IDX_CMP_A) begin
      rbyte = cmpBuf_q[0];
    end else if (idx == IDX_CMP_B) begin
      rbyte = cmpBuf_q[1];
    end else if (idx == IDX_FLAGS) begin
      rbyte = {5'b0_0000, flag_q};
    end else if (idx == IDX_PORT) begin
      rbyte = port_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.pready <= access && !rsp_q.pready;
      rsp_q.pslverr <= access && !rsp_q.pready && !mapped;
      rsp_q.prdata <= (access && !rsp_q.pready && mapped && !apbReq.pwrite) ?
                      {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  assign apbRsp = rsp_q;
  assign pins = pins_q;
  assign flags = flag_q;

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  stopped_count_a: assert property (ctrlB_q[B_CS_HI:0] == 3'b000 && !countWr |=>
    $stable(count_q)) else $error("counter moved while stopped");
  block_match_a: assert property (countWr |=> blockMatch_q && count_q == $past(wbyte))
    else $error("counter write did not land or arm the match block");
  fast_wrap_a: assert property (isFast && tickTop && !countWr |=> count_q == 8'h00)
    else $error("fast mode did not wrap at top");
  ovf_max_a: assert property (wgm == WG_NORMAL && tick && count_q == 8'hFF |=>
    flag_q[F_OVF]) else $error("overflow flag missing at max");
  ctrl_read_a: assert property (rsp_q.pready && idx == IDX_CTRL_B |->
    rsp_q.prdata[7:4] == 4'h0) else $error("force or reserved bits read nonzero");
  resv_a_read_a: assert property (rsp_q.pready && idx == IDX_CTRL_A |->
    rsp_q.prdata[3:2] == 2'b00) else $error("control A reserved bits nonzero");
  clear_match_a: assert property (nonPwm && match[1] && chMode[1] == 2'b10 &&
    !forceHit[1] |=> !wave_q[1]) else $error("clear on match failed");
  pin_take_a: assert property (chMode[1] != 2'b00 ##1 chMode[1] != 2'b00 |=>
    pins.override[1] && pins.out[1] == $past(wave_q[1])) else $error("pin not taken");
  fast_top_a: assert property (isFast && tickTop && chMode[1] == 2'b10 |=>
    wave_q[1]) else $error("fast mode did not set at top");
  pc_up_a: assert property (isPc && match[1] && !countDown_q && chMode[1] == 2'b10 &&
    cmpAct_q[1] != topVal |=> !wave_q[1]) else $error("phase correct up match wrong");
  pc_down_a: assert property (isPc && match[1] && countDown_q && chMode[1] == 2'b10 &&
    cmpAct_q[1] != topVal |=> wave_q[1]) else $error("phase correct down match wrong");
  force_flag_a: assert property (forceHit[1] && !match[1] |=>
    flag_q[F_CMP_B] == $past(flag_q[F_CMP_B])) else $error("forced strobe set a flag");
  pc_turn_a: assert property (isPc && tickTop && !countDown_q && !countWr |=>
    countDown_q) else $error("phase correct did not turn at top");
  ctc_top_a: assert property (wgm == WG_CTC && tickTop && !countWr |=>
    count_q == BOTTOM_VAL) else $error("clear on match mode did not clear at top");
  fast_ovf_a: assert property (wgm == WG_FAST_OCR && tickTop |=> flag_q[F_OVF])
    else $error("overflow flag missing at compare top");
  pc_ovf_a: assert property (isPc && tick && countDown_q && atBottom |=>
    flag_q[F_OVF]) else $error("overflow flag missing at bottom");
  oe_dir_a: assert property (arst_n |=>
    pins.oe == $past(port_q[P_DIR_B:P_DIR_A])) else $error("pin enable not from direction");
  chan_a_toggle_a: assert property (chMode[0] == 2'b01 && wgm == WG_FAST_OCR &&
    match[0] |=> wave_q[0] != $past(wave_q[0])) else $error("channel A did not toggle");
  fast_clear_a: assert property (isFast && match[1] && chMode[1] == 2'b10 &&
    cmpAct_q[1] != topVal |=> !wave_q[1]) else $error("fast mode did not clear on match");
  cmp_hold_a: assert property ((isPc || isFast) && !tickTop |=>
    $stable(cmpAct_q[1])) else $error("compare copy moved away from top");

  // Main scenarios the bench is expected to reach
  ovf_cover_c: cover property (flag_q[F_OVF] && !$past(flag_q[F_OVF]));
  pc_turn_c: cover property (isPc && countDown_q && tick && atBottom);
  force_c: cover property (forceHit[1] && chMode[1] == 2'b01);
  fast_top_c: cover property (isFast && tickTop && chMode[1] == 2'b10);
  ctc_wrap_c: cover property (wgm == WG_CTC && tickTop);

endmodule // tmw_timer

// File: verification/tmw_pin_model.sv
/*
  Pad model for the two waveform pins of the timer.
  Assumes the pin bundle of tmw_timer; each pad carries a weak pull-up.
*/
`timescale 1ns/100ps
module tmw_pin_model (
  input wire tmw_pkg::tmw_pins_t pins,
  output logic [1:0] pinLevel
);
  import tmw_pkg::*;
  // **********
  // Pad resolution
  // **********
  // Undriven pad goes to its pull-up, never holds the last value
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pinLevel[i] = pins.oe[i] ? pins.out[i] : 1'b1;
    end
  end
endmodule // tmw_pin_model

// File: verification/timer2_waveform_control_tb_top.sv
/*
  Self-checking bench for the waveform timer: APB tasks and scenarios.
  Assumes tmw_timer, the pad model and a 200 MHz clock.
*/
`timescale 1ns/100ps
module timer2_waveform_control_tb_top;
  import tmw_pkg::*;
  logic clk_sys;
  logic arst_n;
  tmw_apb_req_t apbReq;
  tmw_apb_rsp_t apbRsp;
  tmw_pins_t pins;
  logic [2:0] flags;
  logic [1:0] pinLevel;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rdVal;
  logic errVal;
  int dv [7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] fcA [4] = '{8'h10, 8'h20, 8'h30, 8'hD0};
  logic [7:0] fcB [4] = '{8'h40, 8'h40, 8'h40, 8'hC0};
  logic [1:0] fcO [4] = '{2'h2, 2'h0, 2'h2, 2'h1};

  tmw_timer dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .pins(pins),
    .flags(flags)
  );
  tmw_pin_model pads (
    .pins(pins),
    .pinLevel(pinLevel)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // **********
  // Reporting
  // **********
  task automatic final_report();
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rng(input string what, input logic [7:0] lo, input logic [7:0] hi,
                     input logic [7:0] got);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("unexpected %s: expected %h to %h seen %h", what, lo, hi, got);
    end
  endtask

  // **********
  // APB master
  // **********
  // Request held until pready; only the hang guard ends a dead wait
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, wr, {2'h0, idx, 2'h0}, {24'h0, wd}};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1);
    chk("pready wait", 8'd2, n[7:0]);
    rdVal = apbRsp.prdata[7:0];
    errVal = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, exp, rdVal);
  endtask

  task automatic rdr(input string what, input logic [7:0] idx, input logic [7:0] lo,
                     input logic [7:0] hi);
    apb(1'b0, idx, 8'h00);
    rng(what, lo, hi, rdVal);
  endtask

  task automatic wait_b(input logic lvl);
    int n;
    n = 0;
    while (pins.out[1] !== lvl && n < 10000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("wave b level", {7'h0, lvl}, {7'h0, pins.out[1]});
  endtask

  // Count read back just after each edge of channel B
  task automatic pwm(input logic [7:0] ctl, input logic [7:0] lo1, input logic [7:0] hi1,
                     input logic [7:0] lo0, input logic [7:0] hi0);
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_A, ctl);
    wr(IDX_CTRL_B, 8'h02);
    wait_b(1'b0);
    wait_b(1'b1);
    rdr("count at rise", IDX_COUNT, lo1, hi1);
    wait_b(1'b0);
    rdr("count at fall", IDX_COUNT, lo0, hi0);
  endtask

  // **********
  // Hang guard
  // **********
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      miscompares++;
      final_report();
    end
  end

  // **********
  // Scenarios
  // **********
  initial begin
    apbReq = '0;
    arst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdc("ctrl a", IDX_CTRL_A, RST_BYTE);
    rdc("ctrl b", IDX_CTRL_B, RST_BYTE);
    rdc("count", IDX_COUNT, RST_BYTE);
    rdc("cmp a", IDX_CMP_A, RST_BYTE);
    wr(IDX_CTRL_A, 8'hFF);
    rdc("ctrl a", IDX_CTRL_A, 8'hF3);
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_CTRL_B, 8'h38);
    rdc("ctrl b", IDX_CTRL_B, 8'h08);
    wr(IDX_CTRL_B, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk("slverr", 8'h01, {7'h0, errVal});
    wr(IDX_COUNT, 8'h5A);
    rdc("count", IDX_COUNT, 8'h5A);
    repeat (50) @(posedge clk_sys);
    rdc("count stopped", IDX_COUNT, 8'h5A);
    // Forced strobes walk the toggle, clear and set output modes
    wr(IDX_PORT, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL_A, fcA[i]);
      wr(IDX_CTRL_B, fcB[i]);
      repeat (4) @(posedge clk_sys);
      chk("wave out", {6'h0, fcO[i]}, {6'h0, pins.out});
      chk("pad level", {6'h0, fcO[i][1], 1'b1}, {6'h0, pinLevel});
      rdc("ctrl b", IDX_CTRL_B, 8'h00);
    end
    chk("override", 8'h03, {6'h0, pins.override});
    chk("flags", 8'h00, {5'h0, flags});
    // Free run past MAX in normal mode, channel B set on match
    wr(IDX_CTRL_A, 8'h30);
    wr(IDX_CMP_A, 8'h40);
    wr(IDX_CMP_B, 8'h10);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CTRL_B, 8'h01);
    repeat (300) @(posedge clk_sys);
    wr(IDX_CTRL_B, 8'h00);
    chk("flags", 8'h07, {5'h0, flags});
    chk("wave set", 8'h02, {6'h0, pins.out});
    wr(IDX_FLAGS, 8'h07);
    repeat (2) @(posedge clk_sys);
    chk("flags", 8'h00, {5'h0, flags});
    // Clear on match keeps the count at or below compare A; channel B clears
    wr(IDX_CTRL_A, 8'h22);
    wr(IDX_CMP_A, 8'h20);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CTRL_B, 8'h01);
    repeat (100) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      rdr("ctc count", IDX_COUNT, 8'h00, 8'h20);
    end
    wr(IDX_CTRL_B, 8'h00);
    chk("flags", 8'h06, {5'h0, flags});
    chk("wave clear", 8'h00, {6'h0, pins.out});
    // Prescaler: 24 ticks per selection, APB latency adds a few
    wr(IDX_CTRL_A, 8'h00);
    for (int c = 1; c < 8; c++) begin
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CTRL_B, c[7:0]);
      repeat (dv[c-1] * 24) @(posedge clk_sys);
      wr(IDX_CTRL_B, 8'h00);
      rdr("prescaled count", IDX_COUNT, 8'd23, 8'd30);
    end
    wr(IDX_CMP_B, 8'h80);
    wr(IDX_COUNT, 8'h00);
    pwm(8'h23, 8'h00, 8'h02, 8'h80, 8'h82);
    pwm(8'h21, 8'h7D, 8'h80, 8'h80, 8'h83);
    final_report();
  end
endmodule // timer2_waveform_control_tb_top
